/* File: core/rcm_pkg.sv */
// Constants and types for the statistics counter mask block.
// Assumes one system clock and a synchronous active-high reset.

package rcm_pkg;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam int          ADDR_W      = 8;             // Window offset bits
  localparam int          DATA_W      = 32;            // Doubleword access
  localparam logic [7:0]  OFF_MASK    = 8'h98;         // rmon_count_mask
  localparam int          MASK_W      = 19;            // Implemented bits
  localparam logic [18:0] MASK_RST    = 19'h0_0000;    // All unmasked
  localparam logic [31:0] RDATA_IDLE  = 32'h0000_0000; // Unmapped / idle

  // ==========================================================
  // Mask bit positions
  // ==========================================================
  localparam int MB_CRC     = 0;   // CRC / alignment errors
  localparam int MB_UNDER   = 1;   // Undersize frames
  localparam int MB_FRAG    = 2;   // Fragments
  localparam int MB_JAB     = 3;   // Jabbers
  localparam int MB_RX_PAIR = 4;   // Receive octets and packets
  localparam int MB_RX_BIN0 = 5;   // First receive length bin
  localparam int MB_COLL    = 11;  // Collisions
  localparam int MB_TX_PAIR = 12;  // Transmit octets and packets
  localparam int MB_TX_BIN0 = 13;  // First transmit length bin
  localparam int N_BINS     = 6;   // 64 .. 1024-1518 octets

  // ==========================================================
  // Increment strobe positions
  // ==========================================================
  localparam int EV_CRC     = 0;
  localparam int EV_UNDER   = 1;
  localparam int EV_FRAG    = 2;
  localparam int EV_JAB     = 3;
  localparam int EV_RX_OCT  = 4;
  localparam int EV_RX_PKT  = 5;
  localparam int EV_RX_BIN0 = 6;
  localparam int EV_COLL    = 12;
  localparam int EV_TX_OCT  = 13;
  localparam int EV_TX_PKT  = 14;
  localparam int EV_TX_BIN0 = 15;
  localparam int EV_W       = 21;
  localparam int LEN_W      = 14;  // Octets added per frame

  // Register access request from the window decoder
  typedef struct packed {
    logic              wr;     // Write strobe, one cycle
    logic              rd;     // Read strobe, one cycle
    logic [ADDR_W-1:0] addr;   // Byte offset in the window
    logic [DATA_W-1:0] wdata;  // Write data
  } rcm_req_s;

  // Counter increment requests (one cycle pulses)
  typedef struct packed {
    logic [EV_W-1:0]  inc;     // One strobe per counter
    logic [LEN_W-1:0] rx_len;  // Octets for the receive octet counter
    logic [LEN_W-1:0] tx_len;  // Octets for the transmit octet counter
  } rcm_evt_s;

  // Per-counter enables from the mask; a pair shares one bit
  function automatic logic [EV_W-1:0] rcm_enables(
    input logic [MASK_W-1:0] m);
    logic [EV_W-1:0] e;
    e = '0;
    e[EV_CRC]    = ~m[MB_CRC];
    e[EV_UNDER]  = ~m[MB_UNDER];
    e[EV_FRAG]   = ~m[MB_FRAG];
    e[EV_JAB]    = ~m[MB_JAB];
    e[EV_RX_OCT] = ~m[MB_RX_PAIR];
    e[EV_RX_PKT] = ~m[MB_RX_PAIR];
    e[EV_COLL]   = ~m[MB_COLL];
    e[EV_TX_OCT] = ~m[MB_TX_PAIR];
    e[EV_TX_PKT] = ~m[MB_TX_PAIR];
    for (int b = 0; b < N_BINS; b++) begin
      e[EV_RX_BIN0+b] = ~m[MB_RX_BIN0+b];
      e[EV_TX_BIN0+b] = ~m[MB_TX_BIN0+b];
    end
    return e;
  endfunction : rcm_enables

endpackage : rcm_pkg

/* File: core/rcm_inc_gate.sv */
// Registered gate between frame classifiers and statistics counters.
// Assumes strobes and mask come from logic on the same clock.
`timescale 1ns/1ns

module rcm_inc_gate
  import rcm_pkg::*;
(
  input  wire logic              i_mclk,   // System clock
  input  wire logic              i_srst,   // Synchronous reset
  input  wire logic [MASK_W-1:0] i_mask,   // Current mask
  input  wire rcm_evt_s          i_evt,    // Raw increment requests
  output rcm_evt_s               o_evt     // Gated requests, registered
);

  // ==========================================================
  // Gate
  // ==========================================================
  rcm_evt_s        evt_q;  // Output register
  logic [EV_W-1:0] en;     // Per-counter enables

  // The strobes and octet amounts are gated; stored counts are never touched
  assign en = rcm_enables(i_mask);

  // One register stage keeps the counters' inputs glitch free
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      evt_q <= '0;
    end else begin
      evt_q.inc <= i_evt.inc & en;
      // Octet amount dropped with its pair bit
      evt_q.rx_len <= en[EV_RX_OCT] ? i_evt.rx_len : '0;
      evt_q.tx_len <= en[EV_TX_OCT] ? i_evt.tx_len : '0;
    end
  end

  assign o_evt = evt_q;

endmodule : rcm_inc_gate

/* File: core/rcm_mask_bank.sv */
// Statistics counter mask register and the increment gate it steers.
// Assumes the window decoder gives one-cycle doubleword strobes with
// the byte offset inside the window, on the system clock.
`timescale 1ns/1ns

// How it works
// - Bit 0 freezes CRC/alignment error counter
// - Bit 1 freezes undersize frame counter
// - Bit 2 freezes fragments counter
// - Bit 3 freezes jabbers counter
// - Bit 4 freezes receive octets and packets
// - Bits 5-10 freeze receive length bins
// - Bit 11 freezes collisions counter
// - Bit 12 freezes transmit octets and packets
// - Bits 13-18 freeze transmit length bins
module rcm_mask_bank
  import rcm_pkg::*;
(
  input  wire logic              i_mclk,     // System clock, 250 MHz
  input  wire logic              i_srst,     // Synchronous reset
  input  wire rcm_req_s          i_req,      // Register access
  input  wire rcm_evt_s          i_evt,      // Raw increment requests
  output logic [DATA_W-1:0]      o_rdata,    // Read data, registered
  output logic                   o_ack,      // Access done, pulse
  output logic [MASK_W-1:0]      o_mask,     // Mask as stored
  output rcm_evt_s               o_evt       // Gated increment requests
);

  // ==========================================================
  // Decode
  // ==========================================================
  logic              hit;       // Offset matches the mask register
  logic [MASK_W-1:0] mask_q;    // rmon_count_mask contents
  logic [DATA_W-1:0] rdata_q;   // Read data register
  logic              ack_q;     // Access acknowledge

  assign hit = (i_req.addr == OFF_MASK);

  // Timing seen from the window decoder and the counters:
  //  - a write taken at edge N is stored at N and steers the strobes
  //    sampled from edge N+1 onward, so a strobe in the same cycle as
  //    the write still sees the old mask;
  //  - a read and a write in one cycle return the old contents, since
  //    the read path looks at the register before it is updated;
  //  - every access is acknowledged one cycle later, mapped or not,
  //    so a stray offset can never stall the host.
  // Only whole doublewords are taken; there are no byte lanes, so a
  // narrower host access must be widened before it reaches this block.

  // ==========================================================
  // Mask register
  // ==========================================================
  // Upper reserved bits are not stored; writes to them are dropped
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      mask_q <= MASK_RST;
    end else if (i_req.wr && hit) begin
      mask_q <= i_req.wdata[MASK_W-1:0];
    end
  end

  // ==========================================================
  // Read path
  // ==========================================================
  // Reserved bits and unmapped offsets read as zero
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rdata_q <= RDATA_IDLE;
    end else if (i_req.rd) begin
      if (hit) begin
        rdata_q <= {{(DATA_W-MASK_W){1'b0}}, mask_q};
      end else begin
        rdata_q <= RDATA_IDLE;
      end
    end
  end

  // Every access, mapped or not, is acknowledged next cycle
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= i_req.rd | i_req.wr;
    end
  end

  // ==========================================================
  // Increment gate
  // ==========================================================
  // Frames themselves never pass here, so traffic is unaffected.
  // The gate sits behind the stored mask so a mask write can never
  // glitch a counter; the price is one cycle of strobe latency.
  rcm_inc_gate u_gate (
    .i_mclk (i_mclk),
    .i_srst (i_srst),
    .i_mask (mask_q),
    .i_evt  (i_evt),
    .o_evt  (o_evt)
  );

  assign o_rdata = rdata_q;
  assign o_ack   = ack_q;
  assign o_mask  = mask_q;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_srst);

  // A write to the mask that sets one bit
  sequence s_set_bit(int b);
    i_req.wr && hit && i_req.wdata[b];
  endsequence

  // A request for one counter while its bit is already stored
  sequence s_masked_req(int b, int e);
    mask_q[b] && i_evt.inc[e];
  endsequence

  chk_crc_held: assert property (
    s_masked_req(MB_CRC, EV_CRC) |=> !o_evt.inc[EV_CRC])
    else $error("CRC error count advanced while masked");

  chk_under_held: assert property (
    s_set_bit(MB_UNDER) ##1 i_evt.inc[EV_UNDER]
      |=> !o_evt.inc[EV_UNDER])
    else $error("Undersize count advanced after mask write");

  chk_frag_held: assert property (
    mask_q[MB_FRAG] |=> !o_evt.inc[EV_FRAG])
    else $error("Fragments count advanced while masked");

  chk_jab_pass: assert property (
    (!mask_q[MB_JAB] && i_evt.inc[EV_JAB]) |=> o_evt.inc[EV_JAB])
    else $error("Jabber strobe lost while unmasked");

  chk_rx_pair: assert property (
    mask_q[MB_RX_PAIR] |=> (!o_evt.inc[EV_RX_OCT]
      && !o_evt.inc[EV_RX_PKT] && o_evt.rx_len == '0))
    else $error("Receive octet/packet pair advanced while masked");

  chk_coll_held: assert property (
    s_masked_req(MB_COLL, EV_COLL) |=> !o_evt.inc[EV_COLL])
    else $error("Collision count advanced while masked");

  chk_tx_pair: assert property (
    (!mask_q[MB_TX_PAIR] && i_evt.inc[EV_TX_PKT])
      |=> (o_evt.inc[EV_TX_PKT] && o_evt.tx_len == $past(i_evt.tx_len)))
    else $error("Transmit pair not passed while unmasked");

  chk_tx_pair_held: assert property (
    mask_q[MB_TX_PAIR] |=> (o_evt.tx_len == '0 && !o_evt.inc[EV_TX_OCT]))
    else $error("Transmit octets advanced while masked");

  chk_only_gate: assert property (
    1'b1 |=> (o_evt.inc == ($past(i_evt.inc) & rcm_enables($past(mask_q)))))
    else $error("Gate altered strobes beyond the mask");

  chk_reserved_zero: assert property (
    o_ack |-> o_rdata[DATA_W-1:MASK_W] == '0)
    else $error("Reserved bits read nonzero");

  chk_write_read: assert property (
    (i_req.wr && hit) ##1 (i_req.rd && hit && !i_req.wr)
      |=> o_rdata[MASK_W-1:0] == $past(i_req.wdata[MASK_W-1:0], 2))
    else $error("Mask readback differs from write");

  // ==========================================================
  // Register access and strobe checks
  // ==========================================================
  // Any register access, mapped or not
  sequence s_access;
    i_req.rd || i_req.wr;
  endsequence

  // A write that lands in the mask register
  sequence s_mask_write;
    i_req.wr && hit;
  endsequence

  chk_ack_pulse: assert property (
    s_access |=> o_ack)
    else $error("Access not acknowledged next cycle");

  chk_ack_idle: assert property (
    !(i_req.rd || i_req.wr) |=> !o_ack)
    else $error("Acknowledge without an access");

  chk_write_lands: assert property (
    s_mask_write |=> o_mask == $past(i_req.wdata[MASK_W-1:0]))
    else $error("Mask write not stored");

  chk_unmapped_keep: assert property (
    (i_req.wr && !hit) |=> $stable(o_mask))
    else $error("Unmapped write changed the mask");

  chk_read_old: assert property (
    (i_req.rd && hit) |=> o_rdata[MASK_W-1:0] == $past(mask_q))
    else $error("Mask read returned wrong contents");

  chk_rx_len_pass: assert property (
    (!mask_q[MB_RX_PAIR] && i_evt.inc[EV_RX_OCT])
      |=> (o_evt.inc[EV_RX_OCT] && o_evt.rx_len == $past(i_evt.rx_len)))
    else $error("Receive octet strobe lost while unmasked");

  // Length bins, one bit each, in ascending order
  for (genvar b = 0; b < N_BINS; b++) begin : g_bins
    chk_rx_bin: assert property (
      s_masked_req(MB_RX_BIN0 + b, EV_RX_BIN0 + b)
        |=> !o_evt.inc[EV_RX_BIN0 + b])
      else $error("Receive bin advanced while masked");

    chk_tx_bin: assert property (
      (!mask_q[MB_TX_BIN0 + b] && i_evt.inc[EV_TX_BIN0 + b])
        |=> o_evt.inc[EV_TX_BIN0 + b])
      else $error("Transmit bin strobe lost while unmasked");
  end

endmodule : rcm_mask_bank

/* File: bench/rcm_mask_bank_test.sv */
// Self-checking bench for the counter mask register and its gate.
// Assumes rcm_pkg and rcm_mask_bank are compiled before this file.
`timescale 1ns/1ns

module rcm_mask_bank_test
  import rcm_pkg::*;
;
  // ==========================================================
  // Stimulus and observed signals
  // ==========================================================
  logic              i_mclk;         // System clock, 4 ns
  logic              i_srst;         // Synchronous reset
  rcm_req_s          i_req;          // Register access request
  rcm_evt_s          i_evt;          // Raw increment strobes
  logic [DATA_W-1:0] o_rdata;        // Read data
  logic              o_ack;          // Access done
  logic [MASK_W-1:0] o_mask;         // Stored mask
  rcm_evt_s          o_evt;          // Gated strobes
  int                error_cnt = 0;  // Mismatches
  int                checked   = 0;  // Comparisons made
  int                cyc       = 0;  // Cycles since start

  rcm_mask_bank uut (
    .i_mclk  (i_mclk),
    .i_srst  (i_srst),
    .i_req   (i_req),
    .i_evt   (i_evt),
    .o_rdata (o_rdata),
    .o_ack   (o_ack),
    .o_mask  (o_mask),
    .o_evt   (o_evt)
  );

  // Free-running clock
  initial i_mclk = 1'b0;
  always #2 i_mclk = ~i_mclk;

  // Hang guard: the whole run needs a few hundred cycles
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt = error_cnt + 1;
      finish_test();
    end
  end

  // ==========================================================
  // Compare and verdict
  // ==========================================================
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_reg

  task automatic cmp_evt(input rcm_evt_s got, input rcm_evt_s exp);
    checked = checked + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_evt

  task automatic finish_test();
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  // ==========================================================
  // Bus and strobe drivers
  // ==========================================================
  // One access; ack must follow for exactly one cycle
  task automatic reg_op(input logic wr, input logic [7:0] addr,
                        input logic [31:0] wd, output logic [31:0] rd);
    @(posedge i_mclk);
    i_req <= '{wr: wr, rd: ~wr, addr: addr, wdata: wd};
    @(posedge i_mclk);
    i_req <= '0;
    #1;
    rd = o_rdata;
    cmp_reg({31'h0, o_ack}, 32'h0000_0001);
    @(posedge i_mclk);
    #1 cmp_reg({31'h0, o_ack}, 32'h0000_0000);
  endtask : reg_op

  // Mask bit that steers each strobe; the two pairs share a bit
  function automatic int ev_bit(input int e);
    if (e < 5) return e;
    if (e < 14) return e - 1;
    return e - 2;
  endfunction : ev_bit

  // Fires every strobe once and checks what passes under mask m
  task automatic send_evt(input logic [MASK_W-1:0] m);
    rcm_evt_s exp;
    exp.rx_len = m[4] ? 14'h0000 : 14'h2abc;
    exp.tx_len = m[12] ? 14'h0000 : 14'h1d35;
    for (int e = 0; e < EV_W; e++) exp.inc[e] = ~m[ev_bit(e)];
    @(posedge i_mclk);
    i_evt <= '{inc: '1, rx_len: 14'h2abc, tx_len: 14'h1d35};
    @(posedge i_mclk);
    i_evt <= '0;
    #1 cmp_evt(o_evt, exp);
    @(posedge i_mclk);
    #1 cmp_evt(o_evt, '0);  // Strobes last one cycle only
  endtask : send_evt

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic test_reset();
    logic [31:0] rd;
    reg_op(1'b0, 8'h98, 32'h0, rd);
    cmp_reg(rd, 32'h0000_0000);
    send_evt('0);
    $display("test reset done");
  endtask : test_reset

  // Each bit alone freezes only its own counters
  task automatic test_each_bit();
    logic [31:0] rd;
    for (int b = 0; b < MASK_W; b++) begin
      reg_op(1'b1, 8'h98, 32'h0000_0001 << b, rd);
      cmp_reg({13'h0, o_mask}, 32'h0000_0001 << b);
      reg_op(1'b0, 8'h98, 32'h0, rd);
      cmp_reg(rd, 32'h0000_0001 << b);
      send_evt(19'h0_0001 << b);
    end
    $display("test each bit done");
  endtask : test_each_bit

  // Full mask, then an unmapped write that must not disturb it
  task automatic test_all_unmapped();
    logic [31:0] rd;
    reg_op(1'b1, 8'h98, 32'h0007_ffff, rd);
    send_evt(19'h7_ffff);
    reg_op(1'b1, 8'h9c, 32'h0000_0000, rd);
    reg_op(1'b0, 8'h9c, 32'h0, rd);
    cmp_reg(rd, 32'h0000_0000);
    reg_op(1'b0, 8'h98, 32'h0, rd);
    cmp_reg(rd, 32'h0007_ffff);
    reg_op(1'b1, 8'h98, 32'h0000_0000, rd);
    send_evt('0);
    $display("test all and unmapped done");
  endtask : test_all_unmapped

  // Write, read with strobes, then a colliding write and read
  task automatic test_back_to_back();
    rcm_evt_s exp;
    exp = '{inc: '1, rx_len: 14'h2abc, tx_len: 14'h1d35};
    exp.inc[EV_UNDER] = 1'b0;
    @(posedge i_mclk);
    i_req <= '{wr: 1'b1, rd: 1'b0, addr: 8'h98, wdata: 32'h0000_0002};
    @(posedge i_mclk);
    i_req <= '{wr: 1'b0, rd: 1'b1, addr: 8'h98, wdata: 32'h0000_0000};
    i_evt <= '{inc: '1, rx_len: 14'h2abc, tx_len: 14'h1d35};
    @(posedge i_mclk);
    i_req <= '{wr: 1'b1, rd: 1'b1, addr: 8'h98, wdata: 32'h0000_0000};
    i_evt <= '0;
    #1;
    cmp_reg({31'h0, o_ack}, 32'h0000_0001);
    cmp_reg(o_rdata, 32'h0000_0002);
    cmp_evt(o_evt, exp);
    @(posedge i_mclk);
    i_req <= '0;
    #1;
    cmp_reg({31'h0, o_ack}, 32'h0000_0001);
    cmp_reg(o_rdata, 32'h0000_0002);
    cmp_reg({13'h0, o_mask}, 32'h0000_0000);
    $display("test back to back done");
  endtask : test_back_to_back

  // Reset in mid-run clears the mask and drops strobes in flight
  task automatic test_mid_reset();
    logic [31:0] rd;
    reg_op(1'b1, 8'h98, 32'h0005_5555, rd);
    @(posedge i_mclk);
    i_srst <= 1'b1;
    i_evt  <= '{inc: '1, rx_len: 14'h2abc, tx_len: 14'h1d35};
    repeat (2) @(posedge i_mclk);
    i_srst <= 1'b0;
    i_evt  <= '0;
    #1;
    cmp_reg({13'h0, o_mask}, 32'h0000_0000);
    cmp_reg({31'h0, o_ack}, 32'h0000_0000);
    cmp_evt(o_evt, '0);
    send_evt('0);
    $display("test mid reset done");
  endtask : test_mid_reset

  // Main sequence
  initial begin
    i_srst = 1'b1;
    i_req  = '0;
    i_evt  = '0;
    repeat (4) @(posedge i_mclk);
    i_srst <= 1'b0;
    #1 cmp_reg({13'h0, o_mask}, 32'h0000_0000);
    test_reset();
    test_each_bit();
    test_all_unmapped();
    test_back_to_back();
    test_mid_reset();
    finish_test();
  end

endmodule : rcm_mask_bank_test
